// ==== include/hds_pkg.sv ====
`default_nettype none
package hds_pkg;
   // Byte offsets of the configuration bank
   localparam logic [7:0] HDS_LANG_UPPER_OFS = 8'h11;
   localparam logic [7:0] HDS_LANG_LOWER_OFS = 8'h12;
   localparam logic [7:0] HDS_MAKER_LEN_OFS = 8'h13;
   localparam logic [7:0] HDS_ITEM_LEN_OFS = 8'h14;
   localparam logic [7:0] HDS_SERIAL_LEN_OFS = 8'h15;
   localparam logic [7:0] HDS_MAKER_BUF_FIRST = 8'h16;
   localparam logic [7:0] HDS_MAKER_BUF_LAST = 8'h53;
   localparam logic [7:0] HDS_ITEM_BUF_FIRST = 8'h54;
   localparam logic [7:0] HDS_ITEM_BUF_LAST = 8'h91;
   localparam logic [7:0] HDS_SERIAL_BUF_FIRST = 8'h92;
   localparam logic [7:0] HDS_SERIAL_BUF_LAST = 8'hCF;
   localparam logic [7:0] HDS_CHARGE_EN_OFS = 8'hD0;
   // String storage: 31 characters of 16 bits, 62 bytes each
   localparam int HDS_TEXT_BYTES = 62;
   localparam logic [7:0] HDS_TEXT_MAX_CHARS = 8'h1F;
   // Charging enable field: bits 4..1 map to ports 4..1
   localparam int HDS_CHARGE_LSB = 1;
   localparam int HDS_CHARGE_MSB = 4;
   localparam logic [7:0] HDS_CHARGE_MASK = 8'h1E;
   // Reset values
   localparam logic [7:0] HDS_LANG_UPPER_RST = 8'h00;
   localparam logic [7:0] HDS_LANG_LOWER_RST = 8'h00;
   localparam logic [7:0] HDS_LEN_RST = 8'h00;
   localparam logic [7:0] HDS_BUF_RST = 8'h00;
   localparam logic [7:0] HDS_CHARGE_RST = 8'h00;
   // Unmapped reads
   localparam logic [7:0] HDS_UNMAPPED_DATA = 8'h00;
endpackage : hds_pkg
`default_nettype wire

// ==== hw/hds_config_bank.sv ====
// How it works
// RL1: Register 0x11 holds the upper byte of the 16-bit language identifier.
// RL2: Register 0x12 holds the lower byte of the 16-bit language identifier.
// RL3: Register 0x13 holds maker string length, at most 31 characters.
// RL4: Register 0x14 holds product string length, at most 31 characters.
// RL5: Register 0x15 holds serial string length, at most 31 characters.
// RL6: Bytes 0x16 to 0x53 hold the maker string, UTF-16LE.
// RL7: Bytes 0x54 to 0x91 hold the product string, 62 bytes.
// RL8: Bytes 0x92 to 0xCF hold the serial string, 62 bytes.
// RL9: Each character sits low byte first, high byte at next address.
// RL10: Characters follow one another at consecutive addresses from area start.
// RL11: Register 0xD0 bits 1 to 4 enable charging on ports 1 to 4.
// RL12: Bits 0, 5, 6 and 7 of 0xD0 are reserved, no effect.
`timescale 1ns/10ps
`default_nettype none
module hds_config_bank
   import hds_pkg::*;
(
   // Clock and reset
   input wire logic CLK_SYS_IN,
   input wire logic RST_N_IN,
   // Byte-wide register port
   input wire logic [7:0] REG_ADDR_IN,
   input wire logic [7:0] REG_WDATA_IN,
   input wire logic REG_WRITE_IN,
   input wire logic REG_READ_IN,
   output logic [7:0] REG_RDATA_OUT,
   output logic REG_HIT_OUT,
   // Descriptor side: character fetch by string and index
   input wire logic [1:0] TEXT_SEL_IN,
   input wire logic [4:0] TEXT_CHAR_IN,
   output logic [15:0] TEXT_CHAR_OUT,
   output logic [7:0] TEXT_LENGTH_OUT,
   // Descriptor values
   output logic [15:0] LANGUAGE_ID_OUT,
   output logic [3:0] PORT_CHARGE_EN_OUT
);

   logic [7:0] language_id_upper;
   logic [7:0] language_id_lower;
   logic [7:0] maker_text_length;
   logic [7:0] item_text_length;
   logic [7:0] serial_text_length;
   logic [7:0] port_charging_enable;
   logic [7:0] maker_text_buffer [HDS_TEXT_BYTES];
   logic [7:0] item_text_buffer [HDS_TEXT_BYTES];
   logic [7:0] serial_text_buffer [HDS_TEXT_BYTES];

   // True when addr lies in [first, last]
   function automatic logic in_area(input logic [7:0] addr, input logic [7:0] first,
                                    input logic [7:0] last);
      in_area = (addr >= first) && (addr <= last);
   endfunction : in_area

   // Byte index within a string area, first address maps to zero
   function automatic logic [5:0] area_index(input logic [7:0] addr, input logic [7:0] first);
      logic [7:0] diff;
      diff = addr - first;
      area_index = diff[5:0];
   endfunction : area_index

   logic hit_maker;
   logic hit_item;
   logic hit_serial;
   logic [5:0] maker_idx;
   logic [5:0] item_idx;
   logic [5:0] serial_idx;

   assign hit_maker = in_area(REG_ADDR_IN, HDS_MAKER_BUF_FIRST, HDS_MAKER_BUF_LAST); // RL6
   assign hit_item = in_area(REG_ADDR_IN, HDS_ITEM_BUF_FIRST, HDS_ITEM_BUF_LAST); // RL7
   assign hit_serial = in_area(REG_ADDR_IN, HDS_SERIAL_BUF_FIRST, HDS_SERIAL_BUF_LAST); // RL8
   assign maker_idx = area_index(REG_ADDR_IN, HDS_MAKER_BUF_FIRST); // RL10
   assign item_idx = area_index(REG_ADDR_IN, HDS_ITEM_BUF_FIRST); // RL10
   assign serial_idx = area_index(REG_ADDR_IN, HDS_SERIAL_BUF_FIRST); // RL10

   // Exact match against one register offset
   function automatic logic is_offset(input logic [7:0] addr, input logic [7:0] ofs);
      is_offset = (addr == ofs);
   endfunction : is_offset

   logic hit_lang_upper;
   logic hit_lang_lower;
   logic hit_maker_len;
   logic hit_item_len;
   logic hit_serial_len;
   logic hit_charge;

   assign hit_lang_upper = is_offset(REG_ADDR_IN, HDS_LANG_UPPER_OFS); // RL1
   assign hit_lang_lower = is_offset(REG_ADDR_IN, HDS_LANG_LOWER_OFS); // RL2
   assign hit_maker_len = is_offset(REG_ADDR_IN, HDS_MAKER_LEN_OFS); // RL3
   assign hit_item_len = is_offset(REG_ADDR_IN, HDS_ITEM_LEN_OFS); // RL4
   assign hit_serial_len = is_offset(REG_ADDR_IN, HDS_SERIAL_LEN_OFS); // RL5
   assign hit_charge = is_offset(REG_ADDR_IN, HDS_CHARGE_EN_OFS); // RL11

   // Identifier and length registers, one process each
   always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         language_id_upper <= HDS_LANG_UPPER_RST;
      end
      else if (REG_WRITE_IN && hit_lang_upper)
      begin
         language_id_upper <= REG_WDATA_IN; // RL1
      end
   end

   always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         language_id_lower <= HDS_LANG_LOWER_RST;
      end
      else if (REG_WRITE_IN && hit_lang_lower)
      begin
         language_id_lower <= REG_WDATA_IN; // RL2
      end
   end

   // Lengths stored raw; clipping happens only on the descriptor side
   always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         maker_text_length <= HDS_LEN_RST;
      end
      else if (REG_WRITE_IN && hit_maker_len)
      begin
         maker_text_length <= REG_WDATA_IN; // RL3
      end
   end

   always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         item_text_length <= HDS_LEN_RST;
      end
      else if (REG_WRITE_IN && hit_item_len)
      begin
         item_text_length <= REG_WDATA_IN; // RL4
      end
   end

   always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         serial_text_length <= HDS_LEN_RST;
      end
      else if (REG_WRITE_IN && hit_serial_len)
      begin
         serial_text_length <= REG_WDATA_IN; // RL5
      end
   end

   // Charging enable; reserved bits are stored and read back but drive nothing
   always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         port_charging_enable <= HDS_CHARGE_RST;
      end
      else if (REG_WRITE_IN && hit_charge)
      begin
         port_charging_enable <= REG_WDATA_IN; // RL11
      end
   end

   // String storage, one byte per address
   always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         for (int i = 0; i < HDS_TEXT_BYTES; i++)
         begin
            maker_text_buffer[i] <= HDS_BUF_RST;
            item_text_buffer[i] <= HDS_BUF_RST;
            serial_text_buffer[i] <= HDS_BUF_RST;
         end
      end
      else if (REG_WRITE_IN)
      begin
         if (hit_maker)
         begin
            maker_text_buffer[maker_idx] <= REG_WDATA_IN; // RL6
         end
         else if (hit_item)
         begin
            item_text_buffer[item_idx] <= REG_WDATA_IN; // RL7
         end
         else if (hit_serial)
         begin
            serial_text_buffer[serial_idx] <= REG_WDATA_IN; // RL8
         end
      end
   end

   // Read decode
   logic [7:0] next_rdata;
   logic next_hit;

   always_comb
   begin
      next_rdata = HDS_UNMAPPED_DATA;
      next_hit = 1'b1;
      if (REG_ADDR_IN == HDS_LANG_UPPER_OFS)
      begin
         next_rdata = language_id_upper;
      end
      else if (REG_ADDR_IN == HDS_LANG_LOWER_OFS)
      begin
         next_rdata = language_id_lower;
      end
      else if (REG_ADDR_IN == HDS_MAKER_LEN_OFS)
      begin
         next_rdata = maker_text_length;
      end
      else if (REG_ADDR_IN == HDS_ITEM_LEN_OFS)
      begin
         next_rdata = item_text_length;
      end
      else if (REG_ADDR_IN == HDS_SERIAL_LEN_OFS)
      begin
         next_rdata = serial_text_length;
      end
      else if (hit_maker)
      begin
         next_rdata = maker_text_buffer[maker_idx];
      end
      else if (hit_item)
      begin
         next_rdata = item_text_buffer[item_idx];
      end
      else if (hit_serial)
      begin
         next_rdata = serial_text_buffer[serial_idx];
      end
      else if (REG_ADDR_IN == HDS_CHARGE_EN_OFS)
      begin
         next_rdata = port_charging_enable;
      end
      else
      begin
         next_hit = 1'b0;
      end
   end

   // Read data is registered one cycle after the strobe
   always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         REG_RDATA_OUT <= HDS_UNMAPPED_DATA;
         REG_HIT_OUT <= 1'b0;
      end
      else if (REG_READ_IN)
      begin
         REG_RDATA_OUT <= next_rdata;
         REG_HIT_OUT <= next_hit;
      end
   end

   // Character fetch for descriptor building
   logic [5:0] char_lo;
   logic [5:0] char_hi;
   logic [15:0] next_char;
   logic [7:0] next_len;

   assign char_lo = {TEXT_CHAR_IN, 1'b0}; // RL10
   assign char_hi = {TEXT_CHAR_IN, 1'b1}; // RL10

   always_comb
   begin
      next_char = 16'h0000;
      next_len = HDS_LEN_RST;
      // Index 31 lies past the 62-byte area and reads as zero
      if (TEXT_CHAR_IN == HDS_TEXT_MAX_CHARS[4:0])
      begin
         next_char = 16'h0000;
      end
      else if (TEXT_SEL_IN == 2'h0)
      begin
         next_char = {maker_text_buffer[char_hi], maker_text_buffer[char_lo]}; // RL9
      end
      else if (TEXT_SEL_IN == 2'h1)
      begin
         next_char = {item_text_buffer[char_hi], item_text_buffer[char_lo]}; // RL9
      end
      else if (TEXT_SEL_IN == 2'h2)
      begin
         next_char = {serial_text_buffer[char_hi], serial_text_buffer[char_lo]}; // RL9
      end
      if (TEXT_SEL_IN == 2'h0)
      begin
         next_len = maker_text_length; // RL3
      end
      else if (TEXT_SEL_IN == 2'h1)
      begin
         next_len = item_text_length; // RL4
      end
      else if (TEXT_SEL_IN == 2'h2)
      begin
         next_len = serial_text_length; // RL5
      end
   end

   always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         TEXT_CHAR_OUT <= 16'h0000;
         TEXT_LENGTH_OUT <= HDS_LEN_RST;
      end
      else
      begin
         TEXT_CHAR_OUT <= next_char;
         // Lengths above 31 are clipped; stored value still reads back raw
         TEXT_LENGTH_OUT <= (next_len > HDS_TEXT_MAX_CHARS) ? HDS_TEXT_MAX_CHARS : next_len;
      end
   end

   // Descriptor values straight from the registers
   always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         LANGUAGE_ID_OUT <= 16'h0000;
      end
      else
      begin
         LANGUAGE_ID_OUT <= {language_id_upper, language_id_lower}; // RL1 RL2
      end
   end

   // Reserved bits 0 and 7:5 never reach a port
   always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         PORT_CHARGE_EN_OUT <= 4'h0;
      end
      else
      begin
         PORT_CHARGE_EN_OUT <= port_charging_enable[HDS_CHARGE_MSB:HDS_CHARGE_LSB]; // RL11 RL12
      end
   end

endmodule : hds_config_bank
`default_nettype wire

// ==== test/hds_config_bank_props.sv ====
`timescale 1ns/10ps
`default_nettype none
module hds_config_bank_props
   import hds_pkg::*;
(
   // Clock and reset
   input wire logic CLK_SYS_IN,
   input wire logic RST_N_IN,
   // Register port
   input wire logic [7:0] REG_ADDR_IN,
   input wire logic [7:0] REG_WDATA_IN,
   input wire logic REG_WRITE_IN,
   input wire logic REG_READ_IN,
   input wire logic [7:0] REG_RDATA_OUT,
   input wire logic REG_HIT_OUT,
   // Descriptor side
   input wire logic [1:0] TEXT_SEL_IN,
   input wire logic [4:0] TEXT_CHAR_IN,
   input wire logic [15:0] TEXT_CHAR_OUT,
   input wire logic [7:0] TEXT_LENGTH_OUT,
   input wire logic [15:0] LANGUAGE_ID_OUT,
   input wire logic [3:0] PORT_CHARGE_EN_OUT
);
   default clocking @(posedge CLK_SYS_IN);
   endclocking
   default disable iff (!RST_N_IN);
   wire logic wr_charge = REG_WRITE_IN && REG_ADDR_IN == 8'hD0;
   wire logic in_map = REG_ADDR_IN >= 8'h11 && REG_ADDR_IN <= 8'hD0;
   a_lang_upper: assert property (
      REG_WRITE_IN && REG_ADDR_IN == 8'h11 |-> ##2 LANGUAGE_ID_OUT[15:8] == $past(REG_WDATA_IN, 2))
      else $error("language upper byte wrong");
   a_lang_lower: assert property (
      REG_WRITE_IN && REG_ADDR_IN == 8'h12 |-> ##2 LANGUAGE_ID_OUT[7:0] == $past(REG_WDATA_IN, 2))
      else $error("language lower byte wrong");
   a_charge_field: assert property (
      wr_charge |-> ##2 PORT_CHARGE_EN_OUT == $past(REG_WDATA_IN[4:1], 2))
      else $error("charge enables wrong");
   a_charge_quiet: assert property (
      !$past(wr_charge, 2) |-> $stable(PORT_CHARGE_EN_OUT))
      else $error("charge enables moved without a write");
   a_length_limit: assert property (TEXT_LENGTH_OUT <= 8'h1F)
      else $error("text length above limit");
   a_index_end: assert property (TEXT_CHAR_IN == 5'h1F |=> TEXT_CHAR_OUT == 16'h0000)
      else $error("character past the end not zero");
   a_unmapped_read: assert property (
      REG_READ_IN && !in_map |=> !REG_HIT_OUT && REG_RDATA_OUT == 8'h00)
      else $error("unmapped read answered");
   a_mapped_hit: assert property (REG_READ_IN && in_map |=> REG_HIT_OUT)
      else $error("mapped read missed");
   a_read_holds: assert property (
      !REG_READ_IN |=> $stable(REG_RDATA_OUT) && $stable(REG_HIT_OUT))
      else $error("read data moved without a read");
endmodule : hds_config_bank_props
bind hds_config_bank hds_config_bank_props u_props (.CLK_SYS_IN, .RST_N_IN, .REG_ADDR_IN,
   .REG_WDATA_IN, .REG_WRITE_IN, .REG_READ_IN, .REG_RDATA_OUT, .REG_HIT_OUT, .TEXT_SEL_IN,
   .TEXT_CHAR_IN, .TEXT_CHAR_OUT, .TEXT_LENGTH_OUT, .LANGUAGE_ID_OUT, .PORT_CHARGE_EN_OUT);
`default_nettype wire

// ==== test/hds_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module hds_host_model (
   // Clock
   input wire logic clk_in,
   // Character fetch
   input wire logic [15:0] char_in,
   output logic [1:0] sel_out,
   output logic [4:0] index_out
);
   initial
   begin
      sel_out = 2'h3;
      index_out = 5'h00;
   end
   // Bank answers one edge later, so take it at the following falling edge
   task automatic fetch(input logic [1:0] sel, input logic [4:0] idx, output logic [15:0] ch);
      @(negedge clk_in);
      sel_out = sel;
      index_out = idx;
      @(negedge clk_in);
      ch = char_in;
   endtask : fetch
endmodule : hds_host_model
`default_nettype wire

// ==== test/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb
   import hds_pkg::*;
();
   logic clk, rst_n, wr_en, rd_en, hit;
   logic [7:0] addr, wdata, rdata, tlen;
   logic [1:0] tsel;
   logic [4:0] tidx;
   logic [15:0] tchar, lang, got;
   logic [3:0] chg;
   logic [7:0] mem [256];
   logic [31:0] lfsr;
   int bad_count, num_checks;
   hds_config_bank uut (.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .REG_ADDR_IN(addr),
      .REG_WDATA_IN(wdata), .REG_WRITE_IN(wr_en), .REG_READ_IN(rd_en), .REG_RDATA_OUT(rdata),
      .REG_HIT_OUT(hit), .TEXT_SEL_IN(tsel), .TEXT_CHAR_IN(tidx), .TEXT_CHAR_OUT(tchar),
      .TEXT_LENGTH_OUT(tlen), .LANGUAGE_ID_OUT(lang), .PORT_CHARGE_EN_OUT(chg));
   hds_host_model host (.clk_in(clk), .char_in(tchar), .sel_out(tsel), .index_out(tidx));
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   function automatic logic [7:0] rnd8();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr[7:0];
   endfunction : rnd8
   function automatic logic mapped(input logic [7:0] a);
      return a >= 8'h11 && a <= 8'hD0;
   endfunction : mapped
   function automatic logic [15:0] exp_char(input logic [1:0] s, input logic [4:0] i);
      int base;
      base = (s == 2'h0) ? 'h16 : (s == 2'h1) ? 'h54 : 'h92;
      if (s == 2'h3 || i == 5'h1F) return 16'h0000;
      return {mem[base + 2 * i + 1], mem[base + 2 * i]};
   endfunction : exp_char
   function automatic logic [7:0] exp_len(input logic [1:0] s);
      if (s == 2'h3) return 8'h00;
      return (mem[8'h13 + s] > 8'h1F) ? 8'h1F : mem[8'h13 + s];
   endfunction : exp_len
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Strobe stays up so back-to-back writes land on successive edges
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      wr_en = 1'b1;
      addr = a;
      wdata = d;
      if (mapped(a)) mem[a] = d;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(negedge clk);
      wr_en = 1'b0;
      rd_en = 1'b1;
      addr = a;
      @(negedge clk);
      rd_en = 1'b0;
      check(rdata, mem[a]);
      check(hit, mapped(a));
   endtask : rd
   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test
   initial
   begin
      repeat (100000) @(posedge clk);
      bad_count++;
      finish_test;
   end
   initial
   begin
      logic [7:0] d;
      logic [7:0] pat [6];
      rst_n = 1'b0;
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      bad_count = 0;
      num_checks = 0;
      lfsr = 32'hA0CB598F;
      foreach (mem[i]) mem[i] = 8'h00;
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      for (int a = 'h10; a < 'h17; a++) rd(a[7:0]);
      rd(8'hD0);
      $display("test reset values done");
      for (int a = 0; a < 256; a++) wr(a[7:0], rnd8());
      // Length boundary values around the 31 character limit
      wr(8'h13, 8'h1F);
      wr(8'h14, 8'h20);
      wr(8'h15, 8'hFF);
      for (int a = 0; a < 256; a++) rd(a[7:0]);
      check(lang, {mem[8'h11], mem[8'h12]});
      $display("test register map done");
      pat = '{8'h00, 8'h1E, 8'hE1, 8'hFF, 8'h02, 8'h10};
      foreach (pat[k])
      begin
         d = (k == 4) ? rnd8() : pat[k];
         wr(8'hD0, d);
         @(negedge clk);
         wr_en = 1'b0;
         @(negedge clk);
         check(chg, d[4:1]);
      end
      $display("test charging enables done");
      for (int s = 0; s < 4; s++)
         for (int i = 0; i < 32; i++)
         begin
            host.fetch(s[1:0], i[4:0], got);
            check(got, exp_char(s[1:0], i[4:0]));
            check(tlen, exp_len(s[1:0]));
         end
      repeat (40)
      begin
         d = rnd8();
         host.fetch(d[6:5], d[4:0], got);
         check(got, exp_char(d[6:5], d[4:0]));
      end
      $display("test string fetch done");
      finish_test;
   end
endmodule : tb
`default_nettype wire
